/* bcr_regs.v */
// Register bank of the burner remote command gateway.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defs.vh"


module bcr_regs #(
  parameter [31:0] SEC_CYCLES = `BCR_SEC_CYCLES,
  parameter [7:0]  HOLD_S     = `BCR_HOLD_LIMIT_S,
  parameter integer DIAG_USED = `BCR_DIAG_WORDS
) (
  input  wire         sys_clk,
  input  wire         rst,
  input  wire         wr_en,
  input  wire [15:0]  wr_addr,
  input  wire [15:0]  wr_data,
  input  wire         rd_en,
  input  wire [15:0]  rd_addr,
  output reg  [15:0]  rd_data_reg,
  output reg          rd_valid_reg,
  input  wire [31:0]  controller_sw_version,
  input  wire [31:0]  annunciator_sw_version,
  input  wire [1:0]   flame_amplifier_kind,
  input  wire [15:0]  purge_duration,
  input  wire [239:0] terminal_diag_codes,
  input  wire [15:0]  post_purge_duration,
  input  wire [2:0]   valve_check_mode,
  input  wire [15:0]  valve_check_option,
  input  wire [15:0]  valve_check_duration,
  input  wire         reset_ack,
  output reg          hold_off_reg,
  output reg          force_high_reg,
  output reg          force_low_reg,
  output reg          reset_request_reg
);

  // --------------------------------------------------------------------------
  // Internal state
  // --------------------------------------------------------------------------
  reg  [15:0] remote_command_reg;
  reg  [1:0]  mode_reg;
  reg  [1:0]  mode_next;
  reg         echo_reg;
  reg         reset_pend_next;
  reg         cmd_valid;
  reg         refresh;
  reg  [15:0] rd_word;
  reg  [15:0] status_word;
  reg  [2:0]  valve_word;
  reg  [15:0] diag_index;
  reg  [15:0] diag_word;
  wire        cmd_write;
  wire        sec_tick;
  wire        hold_expired;

  assign cmd_write = wr_en && (wr_addr == `BCR_A_REMOTE_CMD);

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  always @* begin
    case (wr_data[7:0])
      `BCR_CMD_ONEHOT_AUTO,
      `BCR_CMD_ONEHOT_OFF,
      `BCR_CMD_ONEHOT_HIGH,
      `BCR_CMD_ONEHOT_LOW,
      `BCR_CMD_ONEHOT_RESET: begin
        cmd_valid = 1'b1;
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  always @* begin
    mode_next       = mode_reg;
    refresh         = 1'b0;
    reset_pend_next = reset_request_reg;
    if (reset_ack) begin
      reset_pend_next = 1'b0;
    end
    if (hold_expired) begin
      mode_next = `BCR_MODE_AUTO;
    end
    if (cmd_write && cmd_valid) begin
      if (wr_data[`BCR_CMD_AUTO_BIT]) begin
        mode_next = `BCR_MODE_AUTO;
      end
      if (wr_data[`BCR_CMD_OFF_BIT]) begin
        mode_next = `BCR_MODE_OFF;
        refresh   = 1'b1;
      end
      if (wr_data[`BCR_CMD_HIGH_BIT]) begin
        mode_next = `BCR_MODE_HIGH;
        refresh   = 1'b1;
      end
      if (wr_data[`BCR_CMD_LOW_BIT]) begin
        mode_next = `BCR_MODE_LOW;
        refresh   = 1'b1;
      end
      if (wr_data[`BCR_CMD_RESET_BIT]) begin
        reset_pend_next = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Hold refresh supervision
  // --------------------------------------------------------------------------
  bcr_sec_tick #(
    .TICK_CYCLES (SEC_CYCLES)
  ) u_sec_tick (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .restart  (refresh),
    .tick_reg (sec_tick)
  );

  bcr_hold_timer #(
    .LIMIT_S (HOLD_S)
  ) u_hold_timer (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .restart     (refresh),
    .run         (mode_reg != `BCR_MODE_AUTO),
    .tick        (sec_tick),
    .expired_reg (hold_expired)
  );

  // --------------------------------------------------------------------------
  // Command state
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remote_command_reg <= `BCR_RST_WORD;
      mode_reg           <= `BCR_MODE_AUTO;
      echo_reg           <= 1'b0;
      reset_request_reg  <= 1'b0;
      hold_off_reg       <= 1'b0;
      force_high_reg     <= 1'b0;
      force_low_reg      <= 1'b0;
    end else begin
      if (cmd_write) begin
        remote_command_reg <= wr_data;
        echo_reg           <= wr_data[`BCR_CMD_ECHO_BIT];
      end
      mode_reg          <= mode_next;
      reset_request_reg <= reset_pend_next;
      hold_off_reg      <= (mode_next == `BCR_MODE_OFF);
      force_high_reg    <= (mode_next == `BCR_MODE_HIGH);
      force_low_reg     <= (mode_next == `BCR_MODE_LOW);
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always @* begin
    status_word                     = 16'h0000;
    status_word[`BCR_CMD_OFF_BIT]   = hold_off_reg;
    status_word[`BCR_CMD_HIGH_BIT]  = force_high_reg;
    status_word[`BCR_CMD_LOW_BIT]   = force_low_reg;
    status_word[`BCR_CMD_RESET_BIT] = reset_request_reg;
    status_word[`BCR_CMD_ECHO_BIT]  = echo_reg;
  end

  always @* begin
    if (valve_check_mode > `BCR_VALVE_SPLIT) begin
      valve_word = `BCR_VALVE_DISABLED;
    end else begin
      valve_word = valve_check_mode;
    end
  end

  always @* begin
    diag_index = rd_addr - `BCR_A_DIAG_FIRST;
    diag_word  = 16'h0000;
    case (diag_index[3:0])
      4'h0: begin
        diag_word = terminal_diag_codes[15:0];
      end
      4'h1: begin
        diag_word = terminal_diag_codes[31:16];
      end
      4'h2: begin
        diag_word = terminal_diag_codes[47:32];
      end
      4'h3: begin
        diag_word = terminal_diag_codes[63:48];
      end
      4'h4: begin
        diag_word = terminal_diag_codes[79:64];
      end
      4'h5: begin
        diag_word = terminal_diag_codes[95:80];
      end
      4'h6: begin
        diag_word = terminal_diag_codes[111:96];
      end
      4'h7: begin
        diag_word = terminal_diag_codes[127:112];
      end
      4'h8: begin
        diag_word = terminal_diag_codes[143:128];
      end
      4'h9: begin
        diag_word = terminal_diag_codes[159:144];
      end
      4'hA: begin
        diag_word = terminal_diag_codes[175:160];
      end
      4'hB: begin
        diag_word = terminal_diag_codes[191:176];
      end
      4'hC: begin
        diag_word = terminal_diag_codes[207:192];
      end
      4'hD: begin
        diag_word = terminal_diag_codes[223:208];
      end
      4'hE: begin
        diag_word = terminal_diag_codes[239:224];
      end
      default: begin
        diag_word = 16'h0000;
      end
    endcase
  end

  always @* begin
    rd_word = 16'h0000;
    if (rd_addr >= `BCR_A_DIAG_FIRST && rd_addr <= `BCR_A_DIAG_LAST) begin
      if (diag_index < DIAG_USED) begin
        rd_word = diag_word;
      end
    end else begin
      case (rd_addr)
        `BCR_A_CTRL_SW_HI: begin
          rd_word = controller_sw_version[31:16];
        end
        `BCR_A_CTRL_SW_LO: begin
          rd_word = controller_sw_version[15:0];
        end
        `BCR_A_ANN_SW_HI: begin
          rd_word = annunciator_sw_version[31:16];
        end
        `BCR_A_ANN_SW_LO: begin
          rd_word = annunciator_sw_version[15:0];
        end
        `BCR_A_CMD_STATUS: begin
          rd_word = status_word;
        end
        `BCR_A_FLAME_KIND: begin
          rd_word = {14'h0000, flame_amplifier_kind};
        end
        `BCR_A_PURGE: begin
          rd_word = purge_duration;
        end
        `BCR_A_POST_PURGE: begin
          rd_word = post_purge_duration;
        end
        `BCR_A_VALVE_MODE: begin
          rd_word = {13'h0000, valve_word};
        end
        `BCR_A_VALVE_OPTION: begin
          rd_word = valve_check_option;
        end
        `BCR_A_VALVE_TIME: begin
          rd_word = valve_check_duration;
        end
        `BCR_A_REMOTE_CMD: begin
          rd_word = remote_command_reg;
        end
        default: begin
          rd_word = 16'h0000;
        end
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg  <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        rd_data_reg <= rd_word;
      end
    end
  end

endmodule // bcr_regs
`default_nettype wire

/* bcr_defs.vh */
// Constants for the burner remote command register bank.
`ifndef BCR_DEFS_VH
`define BCR_DEFS_VH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define BCR_ADDR_W              16
`define BCR_DATA_W              16
`define BCR_A_CTRL_SW_HI        16'h0050
`define BCR_A_CTRL_SW_LO        16'h0051
`define BCR_A_ANN_SW_HI         16'h0052
`define BCR_A_ANN_SW_LO         16'h0053
`define BCR_A_CMD_STATUS        16'h0054
`define BCR_A_FLAME_KIND        16'h0055
`define BCR_A_PURGE             16'h0056
`define BCR_A_DIAG_FIRST        16'h0057
`define BCR_A_DIAG_LAST         16'h0065
`define BCR_A_POST_PURGE        16'h0066
`define BCR_A_VALVE_MODE        16'h0067
`define BCR_A_VALVE_OPTION      16'h0068
`define BCR_A_VALVE_TIME        16'h0069
`define BCR_A_REMOTE_CMD        16'h007F

// ----------------------------------------------------------------------------
// Command and status bit positions
// ----------------------------------------------------------------------------
`define BCR_CMD_AUTO_BIT        0
`define BCR_CMD_OFF_BIT         1
`define BCR_CMD_HIGH_BIT        2
`define BCR_CMD_LOW_BIT         3
`define BCR_CMD_RESET_BIT       4
`define BCR_CMD_ECHO_BIT        15
`define BCR_CMD_ONEHOT_AUTO     8'h01
`define BCR_CMD_ONEHOT_OFF      8'h02
`define BCR_CMD_ONEHOT_HIGH     8'h04
`define BCR_CMD_ONEHOT_LOW      8'h08
`define BCR_CMD_ONEHOT_RESET    8'h10

// ----------------------------------------------------------------------------
// Hold modes and encodings
// ----------------------------------------------------------------------------
`define BCR_MODE_AUTO           2'h0
`define BCR_MODE_OFF            2'h1
`define BCR_MODE_HIGH           2'h2
`define BCR_MODE_LOW            2'h3
`define BCR_FLAME_STANDARD      2'h0
`define BCR_FLAME_UNKNOWN       2'h1
`define BCR_FLAME_SELFCHECK     2'h2
`define BCR_FLAME_SHUTTER       2'h3
`define BCR_VALVE_DISABLED      3'h0
`define BCR_VALVE_BEFORE        3'h1
`define BCR_VALVE_AFTER         3'h2
`define BCR_VALVE_BOTH          3'h3
`define BCR_VALVE_SPLIT         3'h4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define BCR_RST_WORD            16'h0000
`define BCR_CLK_PERIOD_NS       8
`define BCR_NS_PER_S            1000000000
`define BCR_SEC_CYCLES          (`BCR_NS_PER_S / `BCR_CLK_PERIOD_NS)
`define BCR_HOLD_LIMIT_S        8'h78
`define BCR_DIAG_WORDS          15

`endif

/* bcr_sec_tick.v */
// One-second tick divider with restart.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defs.vh"

module bcr_sec_tick #(
  parameter [31:0] TICK_CYCLES = `BCR_SEC_CYCLES
) (
  input  wire sys_clk,
  input  wire rst,
  input  wire restart,
  output reg  tick_reg
);

  reg [31:0] count_reg;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h00000000;
      tick_reg  <= 1'b0;
    end else if (restart) begin
      count_reg <= 32'h00000000;
      tick_reg  <= 1'b0;
    end else if (count_reg == TICK_CYCLES - 32'h00000001) begin
      count_reg <= 32'h00000000;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h00000001;
      tick_reg  <= 1'b0;
    end
  end

endmodule // bcr_sec_tick
`default_nettype wire

/* bcr_hold_timer.v */
// Seconds counter that flags an unrefreshed remote hold.
`timescale 1ns/10ps
`default_nettype none
`include "bcr_defs.vh"

module bcr_hold_timer #(
  parameter [7:0] LIMIT_S = `BCR_HOLD_LIMIT_S
) (
  input  wire sys_clk,
  input  wire rst,
  input  wire restart,
  input  wire run,
  input  wire tick,
  output reg  expired_reg
);

  reg [7:0] secs_reg;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      secs_reg    <= 8'h00;
      expired_reg <= 1'b0;
    end else if (restart || !run) begin
      secs_reg    <= 8'h00;
      expired_reg <= 1'b0;
    end else if (tick) begin
      if (secs_reg == LIMIT_S - 8'h01) begin
        secs_reg    <= 8'h00;
        expired_reg <= 1'b1;
      end else begin
        secs_reg    <= secs_reg + 8'h01;
        expired_reg <= 1'b0;
      end
    end else begin
      expired_reg <= 1'b0;
    end
  end

endmodule // bcr_hold_timer
`default_nettype wire

/* bcr_regs_monitor.sv */
// Concurrent checks on the ports of the command register bank.
`timescale 1ns/10ps
`default_nettype none
module bcr_regs_monitor #(
  parameter [31:0] SEC_CYCLES = 32'h07735940,
  parameter [7:0]  HOLD_S     = 8'h78
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic        rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic [15:0] rd_data_reg,
  input wire logic        rd_valid_reg,
  input wire logic        reset_ack,
  input wire logic        hold_off_reg,
  input wire logic        force_high_reg,
  input wire logic        force_low_reg,
  input wire logic        reset_request_reg
);
  localparam [39:0] LIMIT = {32'h00000000, HOLD_S} * {8'h00, SEC_CYCLES} + 40'h0000000004;
  logic [39:0] idle_reg;
  logic        last_echo_reg;
  wire cmd_w = wr_en && wr_addr == 16'h007F;
  wire hold_w = cmd_w && (wr_data[7:0] == 8'h02 || wr_data[7:0] == 8'h04 || wr_data[7:0] == 8'h08);
  wire [2:0] holds = {hold_off_reg, force_high_reg, force_low_reg};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_reg <= 40'h0000000000;
    end else if (hold_w) begin
      idle_reg <= 40'h0000000000;
    end else if (idle_reg != 40'hFFFFFFFFFF) begin
      idle_reg <= idle_reg + 40'h0000000001;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_echo_reg <= 1'b0;
    end else if (cmd_w) begin
      last_echo_reg <= wr_data[15];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence cmd_s(v);
    cmd_w && wr_data[7:0] == v;
  endsequence
  sequence echo_s;
    rd_en && rd_addr == 16'h0054;
  endsequence
  a_read_latency: assert property (1'b1 |=> rd_valid_reg == $past(rd_en))
    else $error("read answer not one cycle after request");
  a_echo_bit: assert property (echo_s |=> rd_data_reg[15] == $past(last_echo_reg))
    else $error("status bit 15 does not echo command");
  a_off_decode: assert property (cmd_s(8'h02) |=> holds == 3'b100)
    else $error("off command not decoded");
  a_high_decode: assert property (cmd_s(8'h04) |=> holds == 3'b010)
    else $error("high fire command not decoded");
  a_low_decode: assert property (cmd_s(8'h08) |=> holds == 3'b001)
    else $error("low fire command not decoded");
  a_auto_resume: assert property (cmd_s(8'h01) |=> holds == 3'b000)
    else $error("autonomous command left a hold");
  a_reset_request: assert property (cmd_s(8'h10) |=> reset_request_reg)
    else $error("remote reset not requested");
  a_hold_onehot: assert property ($onehot0(holds))
    else $error("more than one hold active");
  a_hold_expiry: assert property (idle_reg > LIMIT |-> holds == 3'b000)
    else $error("unrefreshed hold not dropped");
endmodule // bcr_regs_monitor
bind bcr_regs bcr_regs_monitor #(.SEC_CYCLES(SEC_CYCLES), .HOLD_S(HOLD_S)) bcr_regs_monitor_inst (
  .sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
  .rd_addr(rd_addr), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .reset_ack(reset_ack),
  .hold_off_reg(hold_off_reg), .force_high_reg(force_high_reg), .force_low_reg(force_low_reg),
  .reset_request_reg(reset_request_reg));
`default_nettype wire

/* bcr_master_model.sv */
// Remote master model that issues word writes and reads.
`timescale 1ns/10ps
`default_nettype none
module bcr_master_model (
  input  wire logic        sys_clk,
  output var  logic        wr_en,
  output var  logic [15:0] wr_addr,
  output var  logic [15:0] wr_data,
  output var  logic        rd_en,
  output var  logic [15:0] rd_addr
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    rd_addr = 16'h0000;
  end
  // One command word per call, bits 5 to 7 zero unless a test asks otherwise.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge sys_clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    rd_addr = ~a;
  endtask
endmodule // bcr_master_model
`default_nettype wire

/* bcr_tb.sv */
// Self-checking testbench of the command register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam [31:0] SEC  = 32'h0000000A;
  localparam [7:0]  HOLD = 8'h03;
  logic sys_clk = 1'b0, rst = 1'b1, reset_ack = 1'b0;
  logic [31:0] ctrl_sw, ann_sw;
  logic [15:0] purge, post, vopt, vtime, lfsr_reg = 16'h5433;
  logic [239:0] diag;
  logic [1:0] flame = 2'h0;
  logic [2:0] vmode = 3'h0;
  wire wr_en, rd_en, rd_valid_reg, hold_off_reg, force_high_reg, force_low_reg, reset_request_reg;
  wire [15:0] wr_addr, wr_data, rd_addr, rd_data_reg;
  logic [15:0] exp_q[$];
  logic [15:0] cmd_t[5] = '{16'h8002, 16'h0004, 16'h7F08, 16'h0022, 16'h8001};
  logic [15:0] st_t[5] = '{16'h8002, 16'h0004, 16'h0008, 16'h0008, 16'h8000};
  integer n_errors = 0, n_compared = 0, i;
  always #4 sys_clk = ~sys_clk;
  function automatic logic [15:0] rnd();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction
  bcr_master_model bcr_master_model_inst (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
  bcr_regs #(.SEC_CYCLES(SEC), .HOLD_S(HOLD)) bcr_regs_inst (.sys_clk(sys_clk), .rst(rst), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg), .controller_sw_version(ctrl_sw), .annunciator_sw_version(ann_sw),
    .flame_amplifier_kind(flame), .purge_duration(purge), .terminal_diag_codes(diag),
    .post_purge_duration(post), .valve_check_mode(vmode), .valve_check_option(vopt),
    .valve_check_duration(vtime), .reset_ack(reset_ack), .hold_off_reg(hold_off_reg),
    .force_high_reg(force_high_reg), .force_low_reg(force_low_reg), .reset_request_reg(reset_request_reg));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] exp);
    chk(outs(), exp);
  endtask
  function automatic logic [15:0] outs();
    return {11'h000, reset_request_reg, force_low_reg, force_high_reg, hold_off_reg, 1'b0};
  endfunction
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bcr_master_model_inst.rd(a);
  endtask
  always @(negedge sys_clk) begin
    if (rd_valid_reg === 1'b1) begin
      if (exp_q.size() == 0) chk(rd_data_reg, 16'hDEAD);
      else chk(rd_data_reg, exp_q.pop_front());
    end
  end
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    ctrl_sw = {rnd(), rnd()};
    ann_sw = {rnd(), rnd()};
    purge = rnd();
    post = rnd();
    vopt = rnd();
    vtime = rnd();
    for (i = 0; i < 15; i++) diag[16*i +: 16] = rnd();
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    rd(16'h0054, 16'h0000);
    rd(16'h007F, 16'h0000);
    rd(16'h0050, ctrl_sw[31:16]);
    rd(16'h0051, ctrl_sw[15:0]);
    rd(16'h0052, ann_sw[31:16]);
    rd(16'h0053, ann_sw[15:0]);
    rd(16'h0056, purge);
    rd(16'h0066, post);
    rd(16'h0068, vopt);
    rd(16'h0069, vtime);
    rd(16'h006A, 16'h0000);
    rd(16'h007E, 16'h0000);
    for (i = 0; i < 15; i++) rd(16'h0057 + i[15:0], diag[16*i +: 16]);
    for (i = 0; i < 4; i++) begin
      flame = i[1:0];
      rd(16'h0055, {14'h0000, i[1:0]});
    end
    for (i = 0; i < 6; i++) begin
      vmode = i[2:0];
      rd(16'h0067, (i < 5) ? i[15:0] : 16'h0000);
    end
    $display("register reads done");
    for (i = 0; i < 5; i++) begin
      bcr_master_model_inst.wr(16'h007F, cmd_t[i]);
      chk_out(st_t[i] & 16'h000E);
      rd(16'h007F, cmd_t[i]);
      rd(16'h0054, st_t[i]);
    end
    bcr_master_model_inst.wr(16'h0054, 16'hFFFF);
    bcr_master_model_inst.wr(16'h0050, 16'hFFFF);
    bcr_master_model_inst.wr(16'h0070, 16'h0002);
    chk_out(16'h0000);
    rd(16'h0054, 16'h8000);
    rd(16'h0050, ctrl_sw[31:16]);
    $display("command decode done");
    bcr_master_model_inst.wr(16'h007F, 16'h0010);
    chk_out(16'h0010);
    rd(16'h0054, 16'h0010);
    reset_ack = 1'b1;
    @(negedge sys_clk);
    reset_ack = 1'b0;
    @(negedge sys_clk);
    chk_out(16'h0000);
    $display("remote reset done");
    bcr_master_model_inst.wr(16'h007F, 16'h0002);
    repeat (2 * SEC) @(negedge sys_clk);
    bcr_master_model_inst.wr(16'h007F, 16'h0002);
    repeat (HOLD * SEC - 5) @(negedge sys_clk);
    chk_out(16'h0002);
    repeat (10) @(negedge sys_clk);
    chk_out(16'h0000);
    rd(16'h0054, 16'h0000);
    $display("hold expiry done");
    bcr_master_model_inst.wr(16'h007F, 16'h8004);
    chk_out(16'h0004);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_out(16'h0000);
    rst = 1'b0;
    rd(16'h0054, 16'h0000);
    rd(16'h007F, 16'h0000);
    $display("mid-run reset done");
    for (i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge sys_clk);
    if (exp_q.size() != 0) chk(16'h0000, 16'hFFFF);
    summarize();
  end
endmodule // tb
`default_nettype wire
